//--- vic_top.sv
// Notes on behaviour
// (RULE1) Source events always set their request flag
// (RULE2) Flag without enable stays, never branches
// (RULE3) Global enable low blocks every interrupt
// (RULE4) Entry pushes next PC, loads vector
// (RULE5) Return-from-interrupt pops PC and resumes
// (RULE6) Pins own vectors; groups share vectors
// (RULE7) Entry clears the global enable
// (RULE8) Flags still latch while enable cleared
// (RULE9) Software may re-enable globally for nesting
// (RULE10) Full stack holds requests until popped
// (RULE11) Simultaneous requests resolved by fixed priority
// (RULE12) Any newly set flag raises wake
// (RULE13) Software presets flag to avoid wake
// (RULE14) Selected pin edge sets pin flag
// (RULE15) Pin branches need global and pin enable
// (RULE16) Edge select: rise, fall, both, off
// (RULE17) Pin interrupt works only when enabled
// (RULE18) Pin entry clears its own flag
// (RULE19) Pull-up choice stays while used
// (RULE20) Misc register: flags 6..4, enables 2..0
// (RULE21) Timer register: flags 7..4, enables 3..0
// (RULE22) Priority order fixed in package constants
`timescale 1ns/10ps
`default_nettype none
module vic_top import vic_pkg::*; (
   input wire logic aclk, // 10 MHz clock
   input wire logic aresetn, // Sync reset, low
   input wire logic [ADDR_W-1:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [ADDR_W-1:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic [3:0] ext_irq_pins, // External pins
   input wire logic [2:0] misc_events, // Serial, eeprom, low voltage
   input wire logic [3:0] timer_events, // T2A, T2P, T1A, T1P
   input wire vic_core_req_t core_req, // Core fetch side
   output vic_core_rsp_t core_rsp, // PC load request
   output logic wake, // Wake from sleep or idle
   output logic [3:0] pin_pullup_en // Pull-up select per pin
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic gie_ff, nxt_gie;
   logic [3:0] ext_e_ff, ext_f_ff, nxt_ext_f, pin_prev_ff, pull_ff;
   logic [7:0] edge_ff;
   logic [2:0] misc_f_ff, misc_e_ff, nxt_misc_f;
   logic [3:0] tmr_f_ff, tmr_e_ff, nxt_tmr_f;
   logic [1:0] mf_pend_ff, grp_prev_ff, nxt_mf;
   logic [PC_W-1:0] stack_ff [STACK_DEPTH];
   logic [SP_W-1:0] sp_ff;
   logic pc_load_ff, wake_ff, bvalid_ff, rvalid_ff;
   logic [PC_W-1:0] pc_target_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;

   // ****************************************************************
   // Register bus decode
   // ****************************************************************
   // Address and data are taken together; one write outstanding at most
   wire aw_fire = awvalid & wvalid & ~bvalid_ff;
   wire ar_fire = arvalid & ~rvalid_ff;
   wire wr_en = aw_fire & wstrb[0];
   wire wr_ctrl = wr_en & (awaddr == OFS_CTRL);
   wire wr_ext = wr_en & (awaddr == OFS_EXT);
   wire wr_edge = wr_en & (awaddr == OFS_EDGE);
   wire wr_misc = wr_en & (awaddr == OFS_MISC);
   wire wr_tmr = wr_en & (awaddr == OFS_TIMER);
   wire wr_pull = wr_en & (awaddr == OFS_PULL);
   wire wr_hit = (awaddr == OFS_CTRL) | (awaddr == OFS_EXT) | (awaddr == OFS_EDGE)
      | (awaddr == OFS_MISC) | (awaddr == OFS_TIMER) | (awaddr == OFS_PULL)
      | (awaddr == OFS_STATUS);
   assign awready = aw_fire;
   assign wready = aw_fire;
   assign arready = ~rvalid_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rresp = rresp_ff;
   assign rdata = rdata_ff;

   // ****************************************************************
   // External pin edge detection
   // ****************************************************************
   logic [3:0] ext_set;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ext
         wire rise = ext_irq_pins[gi] & ~pin_prev_ff[gi];
         wire fall = ~ext_irq_pins[gi] & pin_prev_ff[gi];
         wire [1:0] sel = edge_ff[2*gi+1:2*gi];
         // Pin acts only while its enable is on and an edge is chosen
         assign ext_set[gi] = ext_e_ff[gi] & (((sel == EDGE_RISE) & rise) // see RULE17
            | ((sel == EDGE_FALL) & fall) | ((sel == EDGE_BOTH) & (rise | fall))); // see RULE16
      end
   endgenerate

   // ****************************************************************
   // Request resolution
   // ****************************************************************
   // Shared-vector groups pend on a fresh enabled request in the group
   wire [1:0] grp_act = {|(tmr_f_ff & tmr_e_ff), |(misc_f_ff & misc_e_ff)}; // see RULE6
   wire [1:0] mf_set = grp_act & ~grp_prev_ff;
   wire [5:0] req = {mf_pend_ff, ext_f_ff & ext_e_ff}; // see RULE2, RULE15
   // Lowest index wins; order is the vector table order
   wire [5:0] grant = req & (~req + 6'h01); // see RULE11, RULE22
   wire stack_full = (sp_ff == STACK_FULL_LEVEL);
   wire stack_empty = (sp_ff == '0);
   wire pop_fire = (core_req.ret_pop | core_req.return_from_irq_instr_pop) & ~stack_empty; // see RULE5
   // A full stack or a return in flight defers entry; nothing is lost
   wire take = core_req.boundary & gie_ff & (|req) & ~stack_full & ~pop_fire; // see RULE3, RULE10
   wire call_fire = core_req.call_push & ~stack_full & ~take & ~pop_fire;
   wire [PC_W-1:0] vec = ({PC_W{grant[0]}} & VEC_EXT0) | ({PC_W{grant[1]}} & VEC_EXT1)
      | ({PC_W{grant[2]}} & VEC_EXT2) | ({PC_W{grant[3]}} & VEC_EXT3)
      | ({PC_W{grant[4]}} & VEC_MF_MISC) | ({PC_W{grant[5]}} & VEC_MF_TIMER); // see RULE6
   wire [5:0] svc_clr = take ? grant : 6'h00;
   wire [SP_W-1:0] sp_m1 = sp_ff - 4'h1;
   wire [PC_W-1:0] stack_top = stack_ff[sp_m1[IDX_W-1:0]];

   // ****************************************************************
   // Flag next values: hardware set beats software or auto clear
   // ****************************************************************
   wire [3:0] ext_base = wr_ext ? wdata[7:4] : ext_f_ff;
   wire [2:0] misc_base = wr_misc ? wdata[6:4] : misc_f_ff;
   wire [3:0] tmr_base = wr_tmr ? wdata[7:4] : tmr_f_ff;
   assign nxt_ext_f = (ext_base & ~svc_clr[3:0]) | ext_set; // see RULE14, RULE18
   assign nxt_misc_f = misc_base | misc_events; // see RULE1, RULE8
   assign nxt_tmr_f = tmr_base | timer_events; // see RULE1, RULE8
   assign nxt_mf = (mf_pend_ff & ~svc_clr[5:4]) | mf_set;
   // Entry clears global enable even if software sets it in the same cycle
   assign nxt_gie = take ? 1'b0 : (wr_ctrl ? wdata[CTRL_GIE_BIT] : gie_ff); // see RULE7
   // Wake on any flag going from clear to set; misc and timer enables ignored, pin flags only set while the pin is enabled
   wire any_new = |(ext_set & ~ext_f_ff) | |(misc_events & ~misc_f_ff)
      | |(timer_events & ~tmr_f_ff); // see RULE12

   // ****************************************************************
   // Read mux
   // ****************************************************************
   wire [7:0] status = {1'b0, mf_pend_ff, stack_full, sp_ff};
   wire rd_hit = (araddr == OFS_CTRL) | (araddr == OFS_EXT) | (araddr == OFS_EDGE)
      | (araddr == OFS_MISC) | (araddr == OFS_TIMER) | (araddr == OFS_PULL)
      | (araddr == OFS_STATUS);
   wire [7:0] rd_byte = (araddr == OFS_CTRL) ? {7'h00, gie_ff}
      : (araddr == OFS_EXT) ? {ext_f_ff, ext_e_ff}
      : (araddr == OFS_EDGE) ? edge_ff
      : (araddr == OFS_MISC) ? {1'b0, misc_f_ff, 1'b0, misc_e_ff} // see RULE20
      : (araddr == OFS_TIMER) ? {tmr_f_ff, tmr_e_ff} // see RULE21
      : (araddr == OFS_PULL) ? {4'h0, pull_ff}
      : (araddr == OFS_STATUS) ? status : 8'h00;

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_e_ff <= RST_NIBBLE;
         edge_ff <= RST_EDGE;
         misc_e_ff <= RST_MISC;
         tmr_e_ff <= RST_NIBBLE;
         pull_ff <= RST_NIBBLE;
      end else begin
         if (wr_ext) ext_e_ff <= wdata[3:0];
         if (wr_edge) edge_ff <= wdata[7:0];
         if (wr_misc) misc_e_ff <= wdata[2:0];
         if (wr_tmr) tmr_e_ff <= wdata[3:0];
         if (wr_pull) pull_ff <= wdata[3:0];
      end
   end
   // Pull-up select is never overridden by the interrupt function
   assign pin_pullup_en = pull_ff; // see RULE19

   // Flags, global enable, pin history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gie_ff <= 1'b0;
         ext_f_ff <= RST_NIBBLE;
         misc_f_ff <= RST_MISC;
         tmr_f_ff <= RST_NIBBLE;
         mf_pend_ff <= 2'h0;
         grp_prev_ff <= 2'h0;
         pin_prev_ff <= RST_NIBBLE;
         wake_ff <= 1'b0;
      end else begin
         gie_ff <= nxt_gie;
         ext_f_ff <= nxt_ext_f;
         misc_f_ff <= nxt_misc_f;
         tmr_f_ff <= nxt_tmr_f;
         mf_pend_ff <= nxt_mf;
         grp_prev_ff <= grp_act;
         pin_prev_ff <= ext_irq_pins;
         wake_ff <= any_new;
      end
   end
   assign wake = wake_ff;

   // ****************************************************************
   // Stack and program counter load
   // ****************************************************************
   // Stack words are data; pointer alone needs reset
   always_ff @(posedge aclk) begin
      if (take | call_fire) stack_ff[sp_ff[IDX_W-1:0]] <= core_req.next_pc; // see RULE4
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_ff <= '0;
         pc_load_ff <= 1'b0;
         pc_target_ff <= '0;
      end else begin
         if (take | call_fire) sp_ff <= sp_ff + 4'h1;
         else if (pop_fire) sp_ff <= sp_m1;
         pc_load_ff <= take | pop_fire;
         if (take) pc_target_ff <= vec; // see RULE4
         else if (pop_fire) pc_target_ff <= stack_top; // see RULE5
      end
   end
   assign core_rsp.pc_load = pc_load_ff;
   assign core_rsp.pc_target = pc_target_ff;

   // ****************************************************************
   // Bus responses
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else begin
         if (aw_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
         if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= {24'h00_0000, rd_byte};
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   timer_flag_set_a: assert property ((timer_events != 4'h0) |=>
      ((tmr_f_ff & $past(timer_events)) == $past(timer_events))) // see RULE1
      else $error("timer event did not set flag");
   no_enable_block_a: assert property (((ext_e_ff == 4'h0) && (mf_pend_ff == 2'h0))
      |-> !take) // see RULE2
      else $error("entry without any enabled request");
   gie_block_a: assert property (!gie_ff |=> !pc_load_ff || $past(pop_fire)) // see RULE3
      else $error("entry while global enable low");
   push_vector_a: assert property (take |=> pc_load_ff && (pc_target_ff == $past(vec))
      && (stack_ff[$past(sp_ff[IDX_W-1:0])] == $past(core_req.next_pc))) // see RULE4
      else $error("entry did not push pc and load vector");
   return_from_irq_instr_pop_a: assert property (pop_fire |=> pc_load_ff
      && (pc_target_ff == $past(stack_top)) && (sp_ff == $past(sp_m1))) // see RULE5
      else $error("return did not pop saved pc");
   gie_clear_a: assert property (take |=> !gie_ff ##1 (!pc_load_ff || $past(pop_fire))
      || gie_ff) // see RULE7
      else $error("global enable not cleared on entry");
   full_hold_a: assert property (stack_full |-> !take && (sp_ff <= STACK_FULL_LEVEL)) // see RULE10
      else $error("entry with full stack");
   prio_ext0_a: assert property ((take && req[0]) |=> pc_target_ff == VEC_EXT0) // see RULE11
      else $error("priority order violated");
   wake_pulse_a: assert property (any_new |=> wake_ff) // see RULE12
      else $error("new flag did not raise wake");
   ext_clear_a: assert property ((take && grant[0] && !ext_set[0]) |=> !ext_f_ff[0]) // see RULE18
      else $error("pin flag not cleared on entry");

   // ****************************************************************
   // Flag, grant and stack assertions
   // ****************************************************************

   // Pin edge lands in its flag the next cycle
   pin_flag_set_a: assert property ((ext_set != 4'h0) |=> // see RULE14
      ((ext_f_ff & $past(ext_set)) == $past(ext_set)))
      else $error("pin edge did not set flag");

   // Edge code off keeps pin 0 silent
   edge_off_a: assert property ((edge_ff[1:0] == EDGE_OFF) |-> // see RULE16
      !ext_set[0])
      else $error("disabled edge set flag");

   // Rise code only reacts to a rising pin
   edge_rise_a: assert property (((edge_ff[1:0] == EDGE_RISE) && ext_set[0]) |-> // see RULE16
      (ext_irq_pins[0] && !pin_prev_ff[0]))
      else $error("rise code set flag without rise");

   // No pin enable, no pin flag
   pin_enable_a: assert property ((ext_e_ff == 4'h0) |-> // see RULE17
      (ext_set == 4'h0))
      else $error("pin flag set while pin disabled");

   // Misc events set flags whatever the enables
   misc_flag_set_a: assert property ((misc_events != 3'h0) |=> // see RULE1
      ((misc_f_ff & $past(misc_events)) == $past(misc_events)))
      else $error("misc event did not set flag");

   // Source flags are never lost without a write
   misc_hold_a: assert property (!wr_misc |=> // see RULE8
      ((misc_f_ff & $past(misc_f_ff)) == $past(misc_f_ff)))
      else $error("misc flag lost");

   // Pin flags only drop by write or entry
   pin_hold_a: assert property ((!wr_ext && !take) |=> // see RULE8
      ((ext_f_ff & $past(ext_f_ff)) == $past(ext_f_ff)))
      else $error("pin flag lost");

   // Unused misc bits read as zero
   misc_gap_a: assert property ((ar_fire && (araddr == OFS_MISC)) |=> // see RULE20
      (rdata_ff[7] == 1'b0) && (rdata_ff[3] == 1'b0))
      else $error("unused misc bit read high");

   // Exactly one source wins an entry
   one_grant_a: assert property (take |-> // see RULE11
      $onehot(grant))
      else $error("entry with several grants");

   // Misc group uses its shared vector
   grp_vector_a: assert property ((take && grant[4]) |=> // see RULE6
      (pc_target_ff == VEC_MF_MISC))
      else $error("misc group wrong vector");

   // Group pending drops on its entry
   grp_clear_a: assert property ((take && grant[5] && !mf_set[1]) |=> // see RULE6
      !mf_pend_ff[1])
      else $error("timer group pending not cleared");

   // Pointer never passes the full level
   stack_bound_a: assert property (sp_ff <= STACK_FULL_LEVEL) // see RULE10
      else $error("stack pointer overflow");

   // A call on a full stack is dropped
   call_full_a: assert property ((stack_full && core_req.call_push && !pop_fire) |=> // see RULE10
      (sp_ff == STACK_FULL_LEVEL))
      else $error("call pushed on full stack");

   // Wake only follows a fresh flag
   wake_cause_a: assert property (wake_ff |-> // see RULE12
      $past(any_new))
      else $error("wake without new flag");

   // Pin entry needs both enables
   pin_gate_a: assert property ((take && grant[0]) |-> // see RULE15
      (gie_ff && ext_e_ff[0]))
      else $error("pin entry without enables");

   take_ext_c: cover property (take && grant[0]);
   wake_c: cover property (wake_ff && !pc_load_ff);
   take_group_c: cover property (take && grant[5] ##[1:20] pop_fire);
   full_defer_c: cover property (stack_full && gie_ff && (|req) ##1 pop_fire);
endmodule
`default_nettype wire

//--- vic_pkg.sv
// ****************************************************************
// Shared constants and types
// ****************************************************************
package vic_pkg;
   // Bus and program counter widths
   localparam int ADDR_W = 8;
   localparam int PC_W = 13;
   // Stack geometry: depth, pointer width, entry index width
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 4;
   localparam int IDX_W = 3;
   localparam logic [SP_W-1:0] STACK_FULL_LEVEL = 4'h8;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_EXT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_MISC = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PULL = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
   // Field positions
   localparam int CTRL_GIE_BIT = 0;
   localparam int FLAG_LSB = 4;
   localparam int STAT_FULL_BIT = 4;
   localparam int STAT_MF_LSB = 5;
   // Reset values
   localparam logic [7:0] RST_EDGE = 8'h00;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [2:0] RST_MISC = 3'h0;
   // Edge select codes, two bits per pin
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Vector addresses, in priority order: ext0..ext3, misc group, timer group
   localparam logic [PC_W-1:0] VEC_EXT0 = 13'h0004;
   localparam logic [PC_W-1:0] VEC_EXT1 = 13'h0008;
   localparam logic [PC_W-1:0] VEC_EXT2 = 13'h000C;
   localparam logic [PC_W-1:0] VEC_EXT3 = 13'h0010;
   localparam logic [PC_W-1:0] VEC_MF_MISC = 13'h0014;
   localparam logic [PC_W-1:0] VEC_MF_TIMER = 13'h0018;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Core fetch side
   typedef struct packed {
      logic boundary;
      logic call_push;
      logic ret_pop;
      logic return_from_irq_instr_pop;
      logic [PC_W-1:0] next_pc;
   } vic_core_req_t;
   typedef struct packed {
      logic pc_load;
      logic [PC_W-1:0] pc_target;
   } vic_core_rsp_t;
endpackage

//--- vic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Core fetch model
// ****************************************
module vic_core_model import vic_pkg::*; (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, low
   input wire logic call_cmd, // Call request
   input wire logic ret_cmd, // Plain return request
   input wire logic return_from_irq_instr_cmd, // Interrupt return request
   input wire vic_core_rsp_t core_rsp, // PC load from controller
   output var vic_core_req_t core_req // Fetch side to controller
);
   logic [PC_W-1:0] pc_ff;
   // Fetch stalls in place, so every pushed address is known to the bench
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_ff <= 13'h0100;
      end else if (core_rsp.pc_load) begin
         pc_ff <= core_rsp.pc_target + 13'h0001;
      end
   end
   // Every cycle is a boundary; requests pass straight through
   assign core_req.boundary = 1'b1;
   assign core_req.call_push = call_cmd;
   assign core_req.ret_pop = ret_cmd;
   assign core_req.return_from_irq_instr_pop = return_from_irq_instr_cmd;
   assign core_req.next_pc = pc_ff;
endmodule
`default_nettype wire

//--- vectored_interrupt_controller_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module vectored_interrupt_controller_tb_top import vic_pkg::*;;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wake;
   logic awready, wready, bvalid, arready, rvalid, call_cmd, ret_cmd, return_from_irq_instr_cmd;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, ext_irq_pins, timer_events, pin_pullup_en;
   logic [2:0] misc_events;
   logic [1:0] bresp, rresp, r;
   logic [PC_W-1:0] last_tgt;
   vic_core_req_t core_req;
   vic_core_rsp_t core_rsp;
   int errors = 0, cmp_count = 0, loads = 0, wakes = 0, w0;
   vic_top i_vic_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ext_irq_pins(ext_irq_pins), .misc_events(misc_events), .timer_events(timer_events),
      .core_req(core_req), .core_rsp(core_rsp), .wake(wake), .pin_pullup_en(pin_pullup_en));
   vic_core_model i_vic_core_model (.aclk(aclk), .aresetn(aresetn), .call_cmd(call_cmd),
      .ret_cmd(ret_cmd), .return_from_irq_instr_cmd(return_from_irq_instr_cmd), .core_rsp(core_rsp), .core_req(core_req));
   // ****************************************
   // Clock and monitors
   // ****************************************
   always #50 aclk = ~aclk;
   // Counts one-cycle pulses, looked at in the cycle they stand
   always @(posedge aclk) begin
      if (core_rsp.pc_load === 1'b1) begin
         loads++;
         last_tgt = core_rsp.pc_target;
      end
      if (wake === 1'b1) wakes++;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Address and data offered together, response awaited under a bound
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 100);
      r = bresp;
      bready <= 1'b0;
      if (n >= 100) begin errors++; wrap_up(); end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 100);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 100) begin errors++; wrap_up(); end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      rd(a);
      check(nm, d, exp);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {aclk, awvalid, wvalid, bready, arvalid, rready, call_cmd, ret_cmd, return_from_irq_instr_cmd} = '0;
      {awaddr, araddr, wdata, wstrb, ext_irq_pins, timer_events, misc_events} = '0;
      aresetn = 1'b0;
      tick(8);
      aresetn <= 1'b1;
      tick(1);
      rc(OFS_MISC, 32'h0, "misc reset");
      rc(OFS_TIMER, 32'h0, "timer reset");
      rc(OFS_EDGE, 32'h0, "edge reset");
      rd(8'h1C);
      check("unmapped resp", r, RESP_SLVERR);
      wr(8'h1C, 32'h0);
      check("unmapped write", r, RESP_SLVERR);
      // Flags and enables apart, so no group request is left pending
      wr(OFS_MISC, 32'hF0);
      rc(OFS_MISC, 32'h70, "misc flags");
      wr(OFS_MISC, 32'h0F);
      rc(OFS_MISC, 32'h07, "misc enables");
      wr(OFS_TIMER, 32'hF0);
      rc(OFS_TIMER, 32'hF0, "timer flags");
      wr(OFS_TIMER, 32'h0F);
      rc(OFS_TIMER, 32'h0F, "timer enables");
      wr(OFS_MISC, 32'h0);
      wr(OFS_TIMER, 32'h0);
      // Source event with its enable off, global enable on
      wr(OFS_CTRL, 32'h1);
      w0 = wakes;
      misc_events <= 3'h4;
      tick(1);
      misc_events <= 3'h0;
      tick(3);
      rc(OFS_MISC, 32'h40, "serial flag");
      check("wake", wakes, w0 + 1);
      check("no branch", loads, 0);
      // A flag already set does not wake again
      misc_events <= 3'h4;
      tick(1);
      misc_events <= 3'h0;
      tick(3);
      check("preset no wake", wakes, w0 + 1);
      wr(OFS_MISC, 32'h0);
      wr(OFS_CTRL, 32'h0);
      // Every edge code on pin 1, rising then falling
      for (int c = 0; c < 4; c++) begin
         wr(OFS_EDGE, c << 2);
         wr(OFS_EXT, 32'h02);
         ext_irq_pins <= 4'h2;
         tick(3);
         rc(OFS_EXT, 32'h02 | ((c & 1) << 5), "rise flag");
         wr(OFS_EXT, 32'h02);
         ext_irq_pins <= 4'h0;
         tick(3);
         rc(OFS_EXT, 32'h02 | ((c >> 1) << 5), "fall flag");
      end
      wr(OFS_EXT, 32'h0);
      ext_irq_pins <= 4'h2;
      tick(3);
      rc(OFS_EXT, 32'h0, "pin disabled");
      // Pin 0 entry and return
      wr(OFS_PULL, 32'h5);
      wr(OFS_EDGE, 32'h01);
      wr(OFS_EXT, 32'h01);
      ext_irq_pins <= 4'h1;
      tick(3);
      rc(OFS_EXT, 32'h11, "pin0 flag");
      check("gie off", loads, 0);
      wr(OFS_CTRL, 32'h1);
      tick(3);
      check("entry", loads, 1);
      check("vector", last_tgt, VEC_EXT0);
      rc(OFS_CTRL, 32'h0, "gie cleared");
      rc(OFS_EXT, 32'h01, "pin flag cleared");
      check("pullup", pin_pullup_en, 4'h5);
      return_from_irq_instr_cmd <= 1'b1;
      tick(1);
      return_from_irq_instr_cmd <= 1'b0;
      tick(3);
      check("return", last_tgt, 13'h0100);
      // Pin 3 and timer group pending together
      wr(OFS_TIMER, 32'h01);
      wr(OFS_EDGE, 32'h40);
      wr(OFS_EXT, 32'h08);
      ext_irq_pins <= 4'h8;
      timer_events <= 4'h1;
      tick(1);
      timer_events <= 4'h0;
      tick(2);
      wr(OFS_CTRL, 32'h1);
      tick(3);
      check("priority", last_tgt, VEC_EXT3);
      misc_events <= 3'h1;
      tick(1);
      misc_events <= 3'h0;
      tick(2);
      rc(OFS_TIMER, 32'h11, "timer held");
      rc(OFS_MISC, 32'h10, "misc held");
      return_from_irq_instr_cmd <= 1'b1;
      tick(1);
      return_from_irq_instr_cmd <= 1'b0;
      wr(OFS_CTRL, 32'h1);
      tick(3);
      check("shared vector", last_tgt, VEC_MF_TIMER);
      return_from_irq_instr_cmd <= 1'b1;
      tick(1);
      return_from_irq_instr_cmd <= 1'b0;
      tick(2);
      // Fill the stack, then a pending entry must wait for a pop
      call_cmd <= 1'b1;
      tick(8);
      call_cmd <= 1'b0;
      tick(1);
      rc(OFS_STATUS, 32'h18, "stack full");
      wr(OFS_EDGE, 32'h41);
      wr(OFS_EXT, 32'h01);
      ext_irq_pins <= 4'h9;
      tick(2);
      wr(OFS_CTRL, 32'h1);
      tick(10);
      check("held by full", loads, 6);
      ret_cmd <= 1'b1;
      tick(1);
      ret_cmd <= 1'b0;
      tick(4);
      check("after pop", loads, 8);
      check("late vector", last_tgt, VEC_EXT0);
      wrap_up();
   end
endmodule
`default_nettype wire
